// ===== hw/standby_wake_pkg.sv
// shared constants, register layout and types of the standby select and wake wait block
package standby_wake_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the register bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] PDC_ONE_OFFSET    = 8'h00;
    localparam logic [7:0] CLK_SWITCH_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int STANDBY_SELECT_BIT = 7;
    localparam int WAKE_SEL_MSB       = 6;
    localparam int WAKE_SEL_LSB       = 4;
    localparam int EXT_REQUEST_BIT    = 0;
    localparam int WAIT_CNT_W         = 18;

    typedef struct packed {
        logic standby_select;
        logic wake_wait_sel_hi;
        logic wake_wait_sel_mid;
        logic wake_wait_sel_lo;
    } pdc_one_t;

    localparam pdc_one_t PDC_ONE_RESET     = 4'h0;
    localparam logic     EXT_REQUEST_RESET = 1'b0;

    // ------------------------------------------------------------------
    // wait state counts per wait-select code
    // ------------------------------------------------------------------
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE0 = 18'h02000; // 8,192
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE1 = 18'h04000; // 16,384
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE2 = 18'h08000; // 32,768
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE3 = 18'h10000; // 65,536
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE4 = 18'h20000; // 131,072
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE5 = 18'h00400; // 1,024
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE6 = 18'h00080; // 128
    localparam logic [WAIT_CNT_W-1:0] WAIT_CODE7 = 18'h00010; // 16
    localparam logic [WAIT_CNT_W-1:0] WAIT_MIN   = 18'h00001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequencer states, gray coded along run, standby, wake, switch
    typedef enum logic [1:0] {
        ST_RUN     = 2'h0,
        ST_STANDBY = 2'h1,
        ST_WAKE    = 2'h3,
        ST_SWITCH  = 2'h2
    } seq_state_t;

    // ------------------------------------------------------------------
    // decoders
    // ------------------------------------------------------------------
    function automatic logic [WAIT_CNT_W-1:0] wait_states(input logic [2:0] code);
        case (code)
            3'h0:    wait_states = WAIT_CODE0;
            3'h1:    wait_states = WAIT_CODE1;
            3'h2:    wait_states = WAIT_CODE2;
            3'h3:    wait_states = WAIT_CODE3;
            3'h4:    wait_states = WAIT_CODE4;
            3'h5:    wait_states = WAIT_CODE5;
            3'h6:    wait_states = WAIT_CODE6;
            default: wait_states = WAIT_CODE7;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == PDC_ONE_OFFSET) || (addr == CLK_SWITCH_OFFSET) ||
                    (addr == STATUS_OFFSET);
    endfunction

endpackage

// ===== hw/wake_wait_counter.sv
// down counter of internal rc clock wait states
`timescale 1ns/1ps
`default_nettype none
module wake_wait_counter #(
    parameter int CNT_W = 18
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load,
    input  wire logic             rc_tick,
    output var  logic             busy,
    output var  logic             done
);

    logic [CNT_W-1:0] remain;

    // only rc ticks advance the count, whatever the system clock source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remain <= '0;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain <= load;
                busy   <= 1'b1;
            end else if (busy && rc_tick) begin
                if (remain <= 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remain <= remain - 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== hw/standby_select_wake_wait.sv
// power-down control register, standby sequencer and wake-up wait timer
//
// Notes on behaviour
// - control bit 7 picks sleep (0) or standby (1) on the sleep instruction
// - bits 6..4 set the wait from oscillator start to clock release after standby
// - during the wake wait the system clock comes from the internal rc clock
// - codes 0..3 give 8192, 16384, 32768, 65536 wait states
// - codes 4..7 give 131072, 1024, 128, 16 wait states
// - the wait counter always counts internal rc clock edges
// - same field sets the settle wait when software moves to the external clock
// - software switch settle wait lies between the standby count and twice it
// - bits 3..0 of the control register always read zero
`timescale 1ns/1ps
`default_nettype none
module standby_select_wake_wait
    import standby_wake_pkg::*;
#(
    parameter int WAIT_SHIFT = 0
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rc_clk_in,
    input  wire logic        sleep_exec,
    input  wire logic        wake_event,
    output var  logic        cpu_halt,
    output var  logic        periph_halt,
    output var  logic        osc_enable,
    output var  logic        clock_from_rc,
    output var  logic        clock_release
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pdc_one_t         pdc_one;
    logic             ext_request;
    logic             ext_active;
    seq_state_t       state;
    seq_state_t       next_state;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             aw_got;
    logic             w_got;
    logic             rc_meta;
    logic             rc_sync;
    logic             rc_prev;
    logic             wait_busy;
    logic             wait_done;

    // ------------------------------------------------------------------
    // rc clock edge detection
    // ------------------------------------------------------------------
    // rc clock is foreign to aclk, so it is synchronised and edge detected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            rc_meta <= rc_clk_in;
            rc_sync <= rc_meta;
            rc_prev <= rc_sync;
        end
    end

    wire rc_tick = rc_sync && !rc_prev; // one wait state per rc rising edge

    // ------------------------------------------------------------------
    // wait count selection
    // ------------------------------------------------------------------
    // WAIT_SHIFT only shortens simulations; zero keeps the real counts
    wire [2:0]            wait_code = {pdc_one.wake_wait_sel_hi, pdc_one.wake_wait_sel_mid,
                                       pdc_one.wake_wait_sel_lo};
    wire [WAIT_CNT_W-1:0] wait_full = wait_states(wait_code);
    wire [WAIT_CNT_W-1:0] wait_scal = wait_full >> WAIT_SHIFT;
    wire [WAIT_CNT_W-1:0] wait_load = (wait_scal == '0) ? WAIT_MIN : wait_scal;

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    wire sleep_to_standby = (state == ST_RUN) && sleep_exec && !cpu_halt &&
                            pdc_one.standby_select;
    wire sleep_to_sleep   = (state == ST_RUN) && sleep_exec && !cpu_halt &&
                            !pdc_one.standby_select;
    wire switch_start     = (state == ST_RUN) && !cpu_halt && ext_request && !ext_active &&
                            !sleep_exec;
    wire wake_start       = (state == ST_STANDBY) && wake_event;
    wire wait_start       = wake_start || switch_start;

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (sleep_to_standby) begin
                    next_state = ST_STANDBY;
                end else if (switch_start) begin
                    next_state = ST_SWITCH;
                end
            end
            ST_STANDBY: begin
                if (wake_start) begin
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wait_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_SWITCH: begin
                if (wait_done) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // the switch uses exactly the standby count, the low end of the allowed band
    wake_wait_counter #(
        .CNT_W (WAIT_CNT_W)
    ) u_wait (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (wait_start),
        .load    (wait_load),
        .rc_tick (rc_tick),
        .busy    (wait_busy),
        .done    (wait_done)
    );

    // ------------------------------------------------------------------
    // sequencer registers and clock outputs
    // ------------------------------------------------------------------
    wire ext_drop = !ext_request && ext_active && (state == ST_RUN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= ST_RUN;
            ext_active    <= 1'b0;
            cpu_halt      <= 1'b0;
            periph_halt   <= 1'b0;
            osc_enable    <= 1'b0;
            clock_from_rc <= 1'b1;
            clock_release <= 1'b0;
        end else begin
            state         <= next_state;
            clock_release <= wait_done;
            if (wait_done && state == ST_SWITCH) begin
                ext_active <= 1'b1;
            end else if (ext_drop) begin
                ext_active <= 1'b0;                  // back to rc at once, no wait needed
            end
            if (sleep_to_sleep || sleep_to_standby) begin
                cpu_halt <= 1'b1;
            end else if ((state == ST_RUN && wake_event) || (state == ST_WAKE && wait_done)) begin
                cpu_halt <= 1'b0;
            end
            periph_halt   <= (next_state == ST_STANDBY) || (next_state == ST_WAKE);
            osc_enable    <= (next_state == ST_WAKE) || (next_state == ST_SWITCH) ||
                             (next_state == ST_RUN && ext_request && !ext_drop);
            // rc drives the system clock through both waits
            clock_from_rc <= (next_state == ST_WAKE) || (next_state == ST_SWITCH) ||
                             !(ext_active || (wait_done && state == ST_SWITCH)) || ext_drop;
        end
    end

    // ------------------------------------------------------------------
    // register bus write side
    // ------------------------------------------------------------------
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire b_fire  = s_axi_bvalid && s_axi_bready;
    wire wr_go   = aw_got && w_got && !s_axi_bvalid;
    wire wr_pdc  = wr_go && (aw_addr == PDC_ONE_OFFSET) && w_strb[0];
    wire wr_clk  = wr_go && (aw_addr == CLK_SWITCH_OFFSET) && w_strb[0];

    // address and data are taken independently, the write lands once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            pdc_one       <= PDC_ONE_RESET;
            ext_request   <= EXT_REQUEST_RESET;
        end else begin
            if (aw_fire) begin
                aw_addr       <= s_axi_awaddr;
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
            end
            if (b_fire) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_pdc) begin
                pdc_one <= {w_data[STANDBY_SELECT_BIT], w_data[WAKE_SEL_MSB:WAKE_SEL_LSB]};
            end
            if (wr_clk) begin
                ext_request <= w_data[EXT_REQUEST_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // register bus read side
    // ------------------------------------------------------------------
    // reserved low bits of the control register are never stored, so read zero
    wire [31:0] rd_pdc = {24'h000000, pdc_one.standby_select, wait_code, 4'h0};
    wire [31:0] rd_clk = {31'h00000000, ext_request};
    wire [31:0] rd_sts = {28'h0000000, state, ext_active, wait_busy};
    wire [31:0] rd_mux = (s_axi_araddr == PDC_ONE_OFFSET)    ? rd_pdc :
                         (s_axi_araddr == CLK_SWITCH_OFFSET) ? rd_clk :
                         (s_axi_araddr == STATUS_OFFSET)     ? rd_sts : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ===== hw/standby_select_wake_wait_fix.sv
// no content: see main file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dv/standby_wake_checker.sv
// port-level assertions for the standby select and wake wait block
`timescale 1ns/1ps
`default_nettype none
module standby_wake_checker
    import standby_wake_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        cpu_halt,
    input wire logic        periph_halt,
    input wire logic        clock_from_rc,
    input wire logic        clock_release
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [7:0] ar_q;
    logic       unmapped_rd;
    // address of the read in flight, so read data can be tied to its register
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_q <= s_axi_araddr;
        end
    end
    assign unmapped_rd = (s_axi_araddr != PDC_ONE_OFFSET) && (s_axi_araddr != CLK_SWITCH_OFFSET)
                         && (s_axi_araddr != STATUS_OFFSET);

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    reset_clears_a: assert property ($rose(aresetn) |->
        clock_from_rc && !cpu_halt && !periph_halt)
        else $error("outputs not at reset values after reset");
    release_pulse_a: assert property (clock_release |=> !clock_release)
        else $error("clock release longer than one cycle");
    standby_halts_cpu_a: assert property (periph_halt |-> cpu_halt)
        else $error("peripherals halted while cpu runs");
    wait_on_rc_a: assert property (periph_halt |-> clock_from_rc)
        else $error("standby or wake wait not on rc clock");
    release_ends_a: assert property (clock_release |-> ##[0:2] !periph_halt)
        else $error("halt held after clock release");
    reserved_zero_a: assert property (s_axi_rvalid && ar_q == PDC_ONE_OFFSET
        |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0)
        else $error("reserved control bits read nonzero");
    write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    unmapped_read_a: assert property (rd_taken ##0 unmapped_rd |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule
bind standby_select_wake_wait standby_wake_checker chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .cpu_halt, .periph_halt, .clock_from_rc, .clock_release);
`default_nettype wire

// ===== dv/standby_select_wake_wait_tb_top.sv
// self-checking bench of the standby select and wake wait block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin err_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end
module standby_select_wake_wait_tb_top
    import standby_wake_pkg::*;
;
    // shift 6 keeps the longest wake wait near 2048 rc edges
    localparam int          SHIFT = 6;
    localparam int unsigned WT[8] = '{8192, 16384, 32768, 65536, 131072, 1024, 128, 16};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic        rc_clk_in, sleep_exec, wake_event, cpu_halt, periph_halt, osc_enable;
    logic        clock_from_rc, clock_release;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rc_div;
    int          err_count, n_tests, rc_edges, cyc;

    standby_select_wake_wait #(.WAIT_SHIFT(SHIFT)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_clk_in,
        .sleep_exec,
        .wake_event, .cpu_halt, .periph_halt, .osc_enable, .clock_from_rc, .clock_release);

    // ------------------------------------------------------------------
    // clocks, watchdog and helpers
    // ------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // rc clock at a quarter of aclk, edges counted here to time the waits
    always @(posedge aclk) begin
        rc_div    <= rc_div + 2'h1;
        rc_clk_in <= rc_div[1];
        if (rc_div == 2'h2) rc_edges <= rc_edges + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // shortened counts never reach zero: the shortest wait is one edge
    function automatic int expw(input int c);
        expw = WT[c] >> SHIFT;
        if (expw == 0) expw = 1;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic got;
        got = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                got = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1 && !s_axi_arvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                got = 1'b1;
                s_axi_rready <= 1'b0;
            end
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] v, d;
        logic [1:0]  r;
        logic [7:0]  ex;
        int          e0, n, ne;
        logic        ok;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {rc_clk_in, sleep_exec, wake_event, s_axi_awaddr, s_axi_araddr} = 19'h00000;
        {s_axi_wdata, s_axi_wstrb, rc_div} = 38'h0;
        err_count = 0;
        n_tests   = 0;
        rc_edges  = 0;
        cyc       = 0;
        step(16);
        aresetn <= 1'b1;
        step(1);
        `CHK("reset clock source", 1'b1, clock_from_rc)
        rd(PDC_ONE_OFFSET, d, r);
        `CHK("control reset", 32'h0, d)
        // random writes, three of the eight with lane 0 disabled so nothing lands
        ex = 8'h00;
        v = 32'hA2AF;
        for (int i = 0; i < 8; i++) begin
            v = lfsr(v);
            wr(PDC_ONE_OFFSET, v, {3'h7, v[9]}, r);
            if (v[9]) ex = v[7:0] & 8'hF0;
            rd(PDC_ONE_OFFSET, d, r);
            `CHK("control readback", {24'h0, ex}, d)
        end
        wr(8'h0C, v, 4'hF, r);
        `CHK("unmapped write resp", RESP_SLVERR, r)
        rd(8'h0C, d, r);
        `CHK("unmapped read resp", RESP_SLVERR, r)
        // sleep: cpu halts, peripherals keep running
        wr(PDC_ONE_OFFSET, 32'h0000_0050, 4'hF, r);
        sleep_exec <= 1'b1;
        step(1);
        sleep_exec <= 1'b0;
        step(3);
        `CHK("sleep cpu halt", 1'b1, cpu_halt)
        `CHK("sleep periph run", 1'b0, periph_halt)
        wake_event <= 1'b1;
        step(1);
        wake_event <= 1'b0;
        step(3);
        `CHK("sleep wake", 1'b0, cpu_halt)
        // standby and wake with every wait code
        for (int c = 0; c < 8; c++) begin
            wr(PDC_ONE_OFFSET, {24'h0, 1'b1, c[2:0], 4'h0}, 4'hF, r);
            sleep_exec <= 1'b1;
            step(1);
            sleep_exec <= 1'b0;
            step(3);
            `CHK("standby periph halt", 1'b1, periph_halt)
            wake_event <= 1'b1;
            step(1);
            wake_event <= 1'b0;
            e0 = rc_edges;
            ok = 1'b1;
            while (clock_release !== 1'b1) begin
                step(1);
                if (clock_from_rc !== 1'b1) ok = 1'b0;
            end
            n = rc_edges - e0;
            ne = expw(c);
            `CHK("wake wait on rc clock", 1'b1, ok)
            ok = (n >= ne - 1) && (n <= ne + 2);
            `CHK("wake wait length", 1'b1, ok)
            step(2);
        end
        // software move to the external clock settles on the same count
        // code 3 keeps the settle wait long enough for a crystal at the top frequency
        wr(PDC_ONE_OFFSET, 32'h0000_0030, 4'hF, r);
        wr(CLK_SWITCH_OFFSET, 32'h1, 4'hF, r);
        e0 = rc_edges;
        ne = expw(3);
        while (clock_from_rc !== 1'b0) step(1);
        n = rc_edges - e0;
        ok = (n >= ne - 1) && (n <= 2 * ne + 2);
        `CHK("switch settle length", 1'b1, ok)
        `CHK("switch oscillator on", 1'b1, osc_enable)
        wr(CLK_SWITCH_OFFSET, 32'h0, 4'hF, r);
        step(2);
        `CHK("back on rc clock", 1'b1, clock_from_rc)
        tally_and_finish();
    end
endmodule
`default_nettype wire
